// [rtl/qr_valley_pkg.sv]
/*
  shared constants and carrier types for the quasi-resonant valley-skip core.
  assumes a single 100 mhz clock; analog comparator results arrive synchronous.
*/
package qr_valley_pkg;
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned EVAL_PERIOD_MS = 48;
  localparam int unsigned EVAL_CYCLES = EVAL_PERIOD_MS * 1000 * CLK_MHZ;
  localparam int unsigned SOFT_START_MS = 12;
  localparam int unsigned SOFT_START_STEPS = 4;
  localparam int unsigned SOFT_STEP_CYCLES = (SOFT_START_MS * 1000 * CLK_MHZ) / SOFT_START_STEPS;
  localparam logic [2:0] SKIP_MIN = 3'h1;
  localparam logic [2:0] SKIP_MAX = 3'h7;
  localparam logic [2:0] ZC_MAX = 3'h7;
  localparam logic [2:0] ZC_RESET = 3'h0;
  // current-sense limit codes in millivolts
  localparam logic [9:0] CS_LIMIT_START_MV = 10'h140;
  localparam logic [9:0] CS_LIMIT_FINAL_MV = 10'h3e8;
  localparam logic [9:0] CS_LIMIT_STEP_MV = 10'h0aa;
  localparam logic [2:0] SS_LAST_STEP = 3'h3;

  // feedback comparator results, one per threshold
  typedef struct packed {
    logic above_reset;
    logic above_down;
    logic above_up;
  } fb_cmp_type;

  // the line-dependent threshold selection comes from the analog side
  typedef struct packed {
    logic high_line;
  } line_sense_type;

  typedef enum logic [1:0] {
    ST_PRECHARGE,
    ST_SOFT_START,
    ST_RUN
  } phase_type;
endpackage

// [rtl/qr_valley_skip_counter.sv]
/*
  digital control core: start-up hand-off, 4-step soft-start, 48 ms up/down
  valley-skip counter and switch-on logic. assumes analog comparators deliver
  synchronous levels and the analog side acts on the current-sense limit code.
*/
`timescale 1ns/1ps
`default_nettype none
// Operation
// RULE_01: evaluate feedback every 48 ms period
// RULE_02: below count-up threshold: increment, max 7
// RULE_03: between up and down thresholds: hold
// RULE_04: above count-down threshold: decrement, min 1
// RULE_05: above reset threshold: force to 1
// RULE_06: counter always stays within 1..7
// RULE_07: counter starts at 1
// RULE_08: counter sets zero crossings to skip
// RULE_09: digital switch-on, analog switch-off
// RULE_10: soft-start 12 ms in 4 steps
// RULE_11: limit rises 0.32 V to 1 V
// RULE_12: supply on: stop pre-charge, start soft-start
// RULE_13: up/down thresholds chosen by line level
// RULE_14: zero-crossing counter 0..7, reset at gate-on
// RULE_15: gate on when crossings reach skip count
// RULE_16: sticky threshold flags, cleared each period
module qr_valley_skip_counter #(
  parameter int unsigned EVAL_CYC = qr_valley_pkg::EVAL_CYCLES,
  parameter int unsigned SS_STEP_CYC = qr_valley_pkg::SOFT_STEP_CYCLES
) (
  input wire logic mclk_i, // 100 mhz clock
  input wire logic arst_n_i, // async reset, active low
  input wire logic supply_above_on_i, // supply over turn-on threshold
  input wire qr_valley_pkg::fb_cmp_type fb_cmp_i, // feedback comparators
  input wire qr_valley_pkg::line_sense_type line_i, // detected line level
  input wire logic zero_cross_fall_i, // falling zero crossing pulse
  input wire logic ring_done_i, // ringing suppression expired
  input wire logic off_request_i, // analog switch-off request
  output logic precharge_en_o, // start-up cell enable
  output logic high_line_sel_o, // threshold bank select for comparators
  output logic [9:0] cs_limit_mv_o, // peak current-sense limit, mv
  output logic soft_start_o, // soft-start in progress
  output logic [2:0] skip_count_o, // valley-skip counter
  output logic [2:0] zc_count_o, // zero-crossing count
  output logic gate_o // gate drive
);
  import qr_valley_pkg::*;

  function automatic logic [31:0] cnt_inc(input logic [31:0] v);
    cnt_inc = v + 32'h1;
  endfunction

  function automatic logic [2:0] step_up(input logic [2:0] v);
    step_up = v + 3'h1;
  endfunction

  // limit for a soft-start step: linear rise, the last step lands on the final limit
  function automatic logic [9:0] ss_level(input logic [2:0] step);
    if (step >= SS_LAST_STEP) begin
      ss_level = CS_LIMIT_FINAL_MV;
    end else begin
      ss_level = CS_LIMIT_START_MV + 10'(step) * CS_LIMIT_STEP_MV;
    end
  endfunction

  // counter action for one closed period; the highest threshold flag wins
  function automatic logic [2:0] skip_step(input logic [2:0] cur, input fb_cmp_type flags);
    skip_step = cur;
    if (flags.above_reset) begin
      skip_step = SKIP_MIN; // see RULE_05
    end else if (flags.above_down) begin
      if (cur != SKIP_MIN) begin
        skip_step = cur - 3'h1; // see RULE_04 see RULE_06
      end
    end else if (flags.above_up) begin
      skip_step = cur; // see RULE_03
    end else if (cur != SKIP_MAX) begin
      skip_step = cur + 3'h1; // see RULE_02 see RULE_06
    end
  endfunction

  phase_type phase;
  phase_type next_phase;
  logic [31:0] ss_timer;
  logic [31:0] next_ss_timer;
  logic [2:0] ss_step;
  logic [2:0] next_ss_step;
  logic [9:0] cs_limit;
  logic [9:0] next_cs_limit;
  logic precharge_en;
  logic next_precharge_en;
  logic soft_start;
  logic next_soft_start;

  // start-up and soft-start sequencing
  always_comb begin
    next_phase = phase;
    next_ss_timer = ss_timer;
    next_ss_step = ss_step;
    next_cs_limit = cs_limit;
    unique case (phase)
      ST_PRECHARGE: begin
        if (supply_above_on_i) begin
          next_phase = ST_SOFT_START; // see RULE_12
          next_ss_timer = 32'h0;
          next_ss_step = 3'h0;
          next_cs_limit = ss_level(3'h0); // see RULE_11
        end
      end
      ST_SOFT_START: begin
        if (ss_timer == SS_STEP_CYC - 1) begin
          next_ss_timer = 32'h0;
          if (ss_step == SS_LAST_STEP) begin
            next_phase = ST_RUN; // see RULE_10
            next_cs_limit = CS_LIMIT_FINAL_MV; // see RULE_11
          end else begin
            next_ss_step = step_up(ss_step);
            next_cs_limit = ss_level(step_up(ss_step)); // see RULE_11
          end
        end else begin
          next_ss_timer = cnt_inc(ss_timer); // see RULE_10
        end
      end
      ST_RUN: begin
        next_cs_limit = CS_LIMIT_FINAL_MV;
      end
      default: begin
        next_phase = ST_PRECHARGE;
      end
    endcase
    if (!supply_above_on_i) begin
      next_phase = ST_PRECHARGE;
      next_cs_limit = CS_LIMIT_START_MV;
    end
    next_precharge_en = (next_phase == ST_PRECHARGE); // see RULE_12
    next_soft_start = (next_phase == ST_SOFT_START);
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      phase <= ST_PRECHARGE;
      ss_timer <= 32'h0;
      ss_step <= 3'h0;
      cs_limit <= CS_LIMIT_START_MV;
      precharge_en <= 1'b1;
      soft_start <= 1'b0;
    end else begin
      phase <= next_phase;
      ss_timer <= next_ss_timer;
      ss_step <= next_ss_step;
      cs_limit <= next_cs_limit;
      precharge_en <= next_precharge_en;
      soft_start <= next_soft_start;
    end
  end

  logic running;
  assign running = (phase != ST_PRECHARGE);

  // supply loss drops the gate and the counter at the same edge as the phase
  logic gate_enable;
  assign gate_enable = running && supply_above_on_i;

  // valley-skip counter and 48 ms evaluation
  logic [31:0] eval_timer;
  logic [31:0] next_eval_timer;
  fb_cmp_type seen;
  fb_cmp_type next_seen;
  logic [2:0] skip_count;
  logic [2:0] next_skip_count;
  logic period_end;
  fb_cmp_type acc;

  always_comb begin
    next_eval_timer = eval_timer;
    next_seen = seen;
    next_skip_count = skip_count;
    period_end = (eval_timer == EVAL_CYC - 1);
    acc = seen | fb_cmp_i; // see RULE_16
    if (!gate_enable) begin
      next_eval_timer = 32'h0;
      next_seen = '0;
      next_skip_count = SKIP_MIN; // see RULE_07
    end else if (period_end) begin
      next_eval_timer = 32'h0; // see RULE_01
      next_seen = '0; // see RULE_16
      // flags include this cycle's levels so a crossing on the closing edge still counts
      next_skip_count = skip_step(skip_count, acc); // see RULE_16
    end else begin
      next_eval_timer = cnt_inc(eval_timer);
      next_seen = acc; // see RULE_16
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      eval_timer <= 32'h0;
      seen <= '0;
      skip_count <= SKIP_MIN; // see RULE_07
    end else begin
      eval_timer <= next_eval_timer;
      seen <= next_seen;
      skip_count <= next_skip_count;
    end
  end

  valley_gate_logic u_gate (
    .mclk_i(mclk_i),
    .arst_n_i(arst_n_i),
    .enable_i(gate_enable),
    .zero_cross_fall_i(zero_cross_fall_i),
    .ring_done_i(ring_done_i),
    .off_request_i(off_request_i),
    .skip_count_i(skip_count), // see RULE_08
    .gate_o(gate_o),
    .zc_count_o(zc_count_o)
  );

  assign precharge_en_o = precharge_en; // see RULE_12
  assign high_line_sel_o = line_i.high_line; // see RULE_13
  assign cs_limit_mv_o = cs_limit;
  assign soft_start_o = soft_start;
  assign skip_count_o = skip_count;
endmodule
`default_nettype wire

// [rtl/valley_gate_logic.sv]
/*
  zero-crossing counter and switch-on decision for one switching cycle.
  assumes the ringing suppression timer and switch-off path are outside.
*/
`timescale 1ns/1ps
`default_nettype none
module valley_gate_logic (
  input wire logic mclk_i, // 100 mhz clock
  input wire logic arst_n_i, // async reset, active low
  input wire logic enable_i, // switching allowed
  input wire logic zero_cross_fall_i, // falling zero crossing, one-cycle pulse
  input wire logic ring_done_i, // ringing suppression expired
  input wire logic off_request_i, // analog switch-off from feedback/current sense
  input wire logic [2:0] skip_count_i, // valleys to skip
  output logic gate_o, // gate drive
  output logic [2:0] zc_count_o // zero crossings since turn-off
);
  import qr_valley_pkg::*;

  logic gate;
  logic next_gate;
  logic [2:0] zc_count;
  logic [2:0] next_zc_count;

  always_comb begin
    next_gate = gate;
    next_zc_count = zc_count;
    if (!enable_i) begin
      next_gate = 1'b0;
      next_zc_count = ZC_RESET;
    end else if (gate) begin
      if (off_request_i) begin
        next_gate = 1'b0; // see RULE_09
      end
    end else begin
      if (zero_cross_fall_i && zc_count != ZC_MAX) begin
        next_zc_count = zc_count + 3'h1; // see RULE_14
      end
      if (ring_done_i && zc_count >= skip_count_i) begin
        next_gate = 1'b1; // see RULE_15 see RULE_08 see RULE_09
        next_zc_count = ZC_RESET; // see RULE_14
      end
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      gate <= 1'b0;
      zc_count <= ZC_RESET;
    end else begin
      gate <= next_gate;
      zc_count <= next_zc_count;
    end
  end

  assign gate_o = gate;
  assign zc_count_o = zc_count;
endmodule
`default_nettype wire

// [test/analog_side_model.sv]
/*
  behavioural analog side: feedback comparators, ringing and switch-off.
  assumes the bench picks the feedback band, 0 below all thresholds.
*/
`timescale 1ns/1ps
`default_nettype none
module analog_side_model (
  input wire logic mclk_i, // clock
  input wire logic gate_i, // gate from core
  input wire logic [1:0] fb_lvl_i, // feedback band 0..3
  output qr_valley_pkg::fb_cmp_type fb_cmp_o, // comparators
  output logic zc_fall_o, // falling crossing pulse
  output logic ring_done_o, // ringing over
  output logic off_req_o // switch-off
);
  import qr_valley_pkg::*;
  logic [3:0] t = 4'h0;
  logic g_q = 1'b0;
  assign fb_cmp_o = '{above_reset: fb_lvl_i == 2'h3, above_down: fb_lvl_i >= 2'h2,
    above_up: fb_lvl_i >= 2'h1};
  always @(posedge mclk_i) begin
    g_q <= gate_i;
    t <= (gate_i !== g_q) ? 4'h0 : t + 4'h1;
    zc_fall_o <= !gate_i && t[1:0] == 2'h1;
    ring_done_o <= !gate_i && t >= 4'h5;
    off_req_o <= gate_i && t >= 4'h3;
  end
endmodule
`default_nettype wire

// [test/qr_valley_skip_counter_tb_top.sv]
/*
  self-checking bench for the valley-skip core with the analog model.
  assumes shortened period and step counts set below.
*/
`timescale 1ns/1ps
`default_nettype none
module qr_valley_skip_counter_tb_top;
  import qr_valley_pkg::*;
  localparam int unsigned EVC = 100;
  localparam int unsigned SSC = 20;
  logic mclk_i = 1'b0, arst_n_i = 1'b0, supply = 1'b0, zc, ring, off, pre, bank, ss, gate;
  logic [1:0] fb_lvl = 2'h0;
  line_sense_type line = '0;
  fb_cmp_type fb_cmp;
  logic [9:0] cs;
  logic [2:0] skip, zcc;
  int mismatches = 0, n_checks = 0, rises = 0;
  qr_valley_skip_counter #(.EVAL_CYC(EVC), .SS_STEP_CYC(SSC)) qr_valley_skip_counter_i (.mclk_i(mclk_i),
    .arst_n_i(arst_n_i), .supply_above_on_i(supply), .fb_cmp_i(fb_cmp), .line_i(line), .zero_cross_fall_i(zc),
    .ring_done_i(ring), .off_request_i(off), .precharge_en_o(pre), .high_line_sel_o(bank), .cs_limit_mv_o(cs),
    .soft_start_o(ss), .skip_count_o(skip), .zc_count_o(zcc), .gate_o(gate));
  analog_side_model analog_side_model_i (.mclk_i(mclk_i), .gate_i(gate), .fb_lvl_i(fb_lvl), .fb_cmp_o(fb_cmp),
    .zc_fall_o(zc), .ring_done_o(ring), .off_req_o(off));
  always @(posedge gate) rises++;
  task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // wait n edges, drive the next band on the boundary edge, then check
  task automatic period(input int unsigned n, input logic [1:0] lvl, input logic [2:0] exp);
    repeat (n) @(posedge mclk_i);
    fb_lvl <= lvl;
    #1;
    chk("skip", 10'(exp), 10'(skip));
  endtask
  task automatic t_start();
    supply <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk_i);
      #1;
      if (ss === 1'b1) break;
    end
    chk("precharge", 10'h0, 10'(pre));
    chk("bank", 10'h0, 10'(bank));
    for (int s = 0; s < SOFT_START_STEPS; s++) begin
      chk("cs", (s < int'(SS_LAST_STEP)) ? CS_LIMIT_START_MV + 10'(s) * CS_LIMIT_STEP_MV : CS_LIMIT_FINAL_MV, cs);
      chk("ss", 10'h1, 10'(ss));
      repeat (SSC) @(posedge mclk_i);
      #1;
    end
    chk("cs end", CS_LIMIT_FINAL_MV, cs);
    chk("ss end", 10'h0, 10'(ss));
    period(EVC - SOFT_START_STEPS * SSC, 2'h0, 3'h2);
  endtask
  task automatic t_count();
    for (int k = 3; k <= 7; k++) period(EVC, 2'h0, 3'(k));
    period(EVC, 2'h1, 3'h7);
    period(EVC, 2'h2, 3'h7);
    period(EVC, 2'h3, 3'h6);
    period(EVC, 2'h2, 3'h1);
    period(EVC, 2'h0, 3'h1);
    period(EVC, 2'h1, 3'h2);
    period(EVC, 2'h0, 3'h2);
    period(EVC / 2, 2'h3, 3'h2);
    period(1, 2'h0, 3'h2);
    period(EVC / 2 - 1, 2'h0, 3'h1);
    chk("gate", 10'h1, 10'(rises > 0));
  endtask
  task automatic t_bank_drop();
    @(posedge mclk_i);
    line <= '{high_line: 1'b1};
    supply <= 1'b0;
    #1;
    chk("bank", 10'h1, 10'(bank));
    repeat (2) @(posedge mclk_i);
    #1;
    chk("drop precharge", 10'h1, 10'(pre));
    chk("drop skip", 10'h1, 10'(skip));
  endtask
  initial begin
    forever #5 mclk_i = ~mclk_i;
  end
  initial begin
    #60000;
    mismatches++;
    tally_and_finish();
  end
  initial begin
    repeat (2) @(posedge mclk_i);
    arst_n_i <= 1'b1;
    #1;
    chk("reset skip", 10'h1, 10'(skip));
    @(posedge mclk_i);
    t_start();
    t_count();
    t_bank_drop();
    tally_and_finish();
  end
endmodule
`default_nettype wire

// [test/valley_core_props.sv]
/*
  port assertions for the valley-skip core, bound to its top module.
  assumes one clock domain and an async active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module valley_core_props #(
  parameter int unsigned EVAL_CYC = qr_valley_pkg::EVAL_CYCLES,
  parameter int unsigned SS_STEP_CYC = qr_valley_pkg::SOFT_STEP_CYCLES
) (
  input wire logic mclk_i, // clock
  input wire logic arst_n_i, // reset
  input wire logic supply_above_on_i, // supply ok
  input wire qr_valley_pkg::line_sense_type line_i, // line level
  input wire logic ring_done_i, // ringing over
  input wire logic off_request_i, // switch-off
  input wire logic precharge_en_o, // start-up cell
  input wire logic high_line_sel_o, // bank select
  input wire logic [9:0] cs_limit_mv_o, // limit
  input wire logic soft_start_o, // soft-start
  input wire logic [2:0] skip_count_o, // skip count
  input wire logic [2:0] zc_count_o, // crossings
  input wire logic gate_o // gate
);
  import qr_valley_pkg::*;
  int unsigned ss_cnt, next_ss_cnt, ev_cnt, next_ev_cnt;
  always_comb begin
    next_ss_cnt = soft_start_o ? ss_cnt + 1 : 0;
    next_ev_cnt = (precharge_en_o || ev_cnt == EVAL_CYC - 1) ? 0 : ev_cnt + 1;
  end
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ss_cnt <= 0;
      ev_cnt <= 0;
    end else begin
      ss_cnt <= next_ss_cnt;
      ev_cnt <= next_ev_cnt;
    end
  end
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);
  sequence s_handoff; supply_above_on_i && precharge_en_o; endsequence
  sequence s_ss_begin; !precharge_en_o && soft_start_o && cs_limit_mv_o == CS_LIMIT_START_MV; endsequence
  property p_handoff; s_handoff |=> s_ss_begin; endproperty
  a_handoff: assert property (p_handoff) else $error("start-up hand-off wrong");
  property p_ss_level;
    soft_start_o |-> cs_limit_mv_o == ((ss_cnt / SS_STEP_CYC >= SS_LAST_STEP) ? CS_LIMIT_FINAL_MV
      : CS_LIMIT_START_MV + 10'(ss_cnt / SS_STEP_CYC) * CS_LIMIT_STEP_MV);
  endproperty
  a_ss_level: assert property (p_ss_level) else $error("soft-start level wrong");
  property p_ss_end;
    supply_above_on_i && soft_start_o && ss_cnt == SOFT_START_STEPS * SS_STEP_CYC - 1 |=>
      !soft_start_o && cs_limit_mv_o == CS_LIMIT_FINAL_MV;
  endproperty
  a_ss_end: assert property (p_ss_end) else $error("soft-start end wrong");
  property p_range; skip_count_o >= SKIP_MIN && skip_count_o <= SKIP_MAX; endproperty
  a_range: assert property (p_range) else $error("skip count out of range");
  property p_step;
    $changed(skip_count_o) |-> skip_count_o == SKIP_MIN || skip_count_o == $past(skip_count_o) + 3'h1
      || skip_count_o == $past(skip_count_o) - 3'h1;
  endproperty
  a_step: assert property (p_step) else $error("skip count jumped");
  property p_eval; $changed(skip_count_o) && !precharge_en_o |-> ev_cnt == 0; endproperty
  a_eval: assert property (p_eval) else $error("skip count moved mid-period");
  property p_init; precharge_en_o |-> skip_count_o == SKIP_MIN && !gate_o; endproperty
  a_init: assert property (p_init) else $error("start-up values wrong");
  property p_gate_on;
    $rose(gate_o) |-> $past(ring_done_i) && $past(zc_count_o) >= $past(skip_count_o) && zc_count_o == ZC_RESET;
  endproperty
  a_gate_on: assert property (p_gate_on) else $error("gate rose early");
  property p_off; gate_o && off_request_i |=> !gate_o; endproperty
  a_off: assert property (p_off) else $error("gate ignored switch-off");
  property p_bank; high_line_sel_o == line_i.high_line; endproperty
  a_bank: assert property (p_bank) else $error("bank select wrong");
endmodule
bind qr_valley_skip_counter valley_core_props #(.EVAL_CYC(EVAL_CYC), .SS_STEP_CYC(SS_STEP_CYC)) props_i (
  .mclk_i(mclk_i), .arst_n_i(arst_n_i), .supply_above_on_i(supply_above_on_i), .line_i(line_i),
  .ring_done_i(ring_done_i), .off_request_i(off_request_i), .precharge_en_o(precharge_en_o),
  .high_line_sel_o(high_line_sel_o), .cs_limit_mv_o(cs_limit_mv_o), .soft_start_o(soft_start_o),
  .skip_count_o(skip_count_o), .zc_count_o(zc_count_o), .gate_o(gate_o));
`default_nettype wire
